/* dv/mem_model.sv */
/*
 * Data memory model on the far side of the operand fetch port.
 * Assumes one read strobe per cycle; 256 words, addressed by the low byte.
 */
`timescale 1ns/10ps
module mem_model (
	input  wire logic        clk,
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic      [15:0] mem_rdata
);
	logic [15:0] mem [0:255];

	initial mem_rdata = 16'h0000;

	// data stands only in the cycle after the strobe; a stale word would hide late sampling
	always @(posedge clk) begin
		if (mem_rd) begin
			mem_rdata <= mem[mem_addr[7:0]];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

/* dv/testbench.sv */
/*
 * Self-checking bench of the accumulator subtract datapath: random and corner operations,
 * results read back over the register port. Assumes mem_model as the operand memory.
 */
`timescale 1ns/10ps
module testbench;
	logic                clk = 1'b0, resetn = 1'b0, start = 1'b0, op_uns = 1'b0;
	logic                op_src_present = 1'b0, op_postinc = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
	subdp_pkg::op_kind_t op_kind = subdp_pkg::OP_SINGLE;
	logic [1:0]          op_src = 2'h0, op_dst = 2'h0;
	logic [5:0]          op_shift = 6'h00;
	logic [15:0]         op_addr_x = 16'h0000, op_addr_y = 16'h0000, mem_addr, mem_rdata, ptr_next;
	logic [7:0]          bus_addr = 8'h00;
	logic [31:0]         bus_wdata = 32'h0000_0000, bus_rdata;
	logic                busy, done, mem_rd, ptr_wr, carry_flag;
	logic [3:0]          acc_overflow_flag;
	int                  n_fail = 0, n_tests = 0, cyc = 0;

	acc_subtract_datapath dut (.clk, .resetn, .start, .op_kind, .op_uns, .op_src_present,
		.op_src, .op_dst, .op_shift, .op_addr_x, .op_addr_y, .op_postinc, .busy, .done,
		.mem_rd, .mem_addr, .mem_rdata, .ptr_wr, .ptr_next, .carry_flag, .acc_overflow_flag,
		.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
	mem_model mem_i (.clk, .mem_rd, .mem_addr, .mem_rdata);

	always #12.5 clk = ~clk;

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// about 20 cycles an operation, so this only trips on a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_fail++;
			finish_test;
		end
	end

	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h got %h", nm, e, g);
		end
	endtask

	task automatic bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic br(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	function automatic logic [7:0] aofs(input logic [7:0] base, input logic [1:0] i);
		return base + subdp_pkg::ACC_STRIDE * {6'h00, i};
	endfunction

	task automatic wacc(input logic [1:0] i, input logic [39:0] v);
		bw(aofs(subdp_pkg::ACC_LO_OFS, i), v[31:0]);
		bw(aofs(subdp_pkg::ACC_HI_OFS, i), {24'h0, v[39:32]});
	endtask

	// returns {overflow, carry, result}
	function automatic logic [41:0] calc(input subdp_pkg::op_kind_t k, input logic u,
		input logic [5:0] sh, input logic [39:0] a, input logic [15:0] w0, w1,
		input logic [3:0] ctl, input logic cin);
		logic [39:0] b, r;
		logic [40:0] s, d;
		logic [32:0] d32;
		logic        bi, ov, so, sg;
		int          n;
		bi = 1'b0;
		so = 1'b0;
		n = $signed(sh);
		b = (u || !ctl[0]) ? {24'h0, w0} : {{24{w0[15]}}, w0};
		sg = b[39];
		case (k)
		subdp_pkg::OP_SHIFT: begin
			if (n < 0) b = $signed(b) >>> (-n);
			else b = b << n;
			// narrow, non-compat: the shifted operand must fit 32 bits
			so = !ctl[3] && !ctl[1] && !(&b[39:31] || !(|b[39:31]));
			if (so && ctl[2]) b = sg ? subdp_pkg::SAT_NEG32 : subdp_pkg::SAT_POS32;
		end
		subdp_pkg::OP_DBL: b = ctl[0] ? {{8{w0[15]}}, w0, w1} : {8'h00, w0, w1};
		subdp_pkg::OP_BORROW: begin
			b = {24'h0, w0};
			bi = ~cin;
		end
		subdp_pkg::OP_DUAL: begin
			a = (ctl[0] ? {{24{w0[15]}}, w0} : {24'h0, w0}) << 16;
			b = (ctl[0] ? {{24{w1[15]}}, w1} : {24'h0, w1}) << 16;
		end
		default: ;
		endcase
		s = {a[39], a} - {b[39], b} - {40'h0, bi};
		d = {1'b0, a} - {1'b0, b} - {40'h0, bi};
		d32 = {1'b0, a[31:0]} - {1'b0, b[31:0]} - {32'h0, bi};
		ov = ctl[1] ? s[40] ^ s[39] : !(&s[40:31] || !(|s[40:31]));
		r = s[39:0];
		if (ov && ctl[2]) begin
			if (ctl[1]) r = s[40] ? subdp_pkg::SAT_NEG40 : subdp_pkg::SAT_POS40;
			else r = s[40] ? subdp_pkg::SAT_NEG32 : subdp_pkg::SAT_POS32;
		end
		// a shift overflow is flagged but does not clamp the difference
		return {ov | so, ctl[1] ? ~d[40] : ~d32[32], r};
	endfunction

	task automatic run_op(input subdp_pkg::op_kind_t k, input logic [3:0] ctl,
		input logic u, sp, cin, pi, poke, input logic [1:0] s, d, input logic [5:0] sh,
		input logic [15:0] ax, ay, input logic [39:0] as, ad);
		logic [39:0] acc [4];
		logic [39:0] m, got;
		logic [31:0] q;
		logic [15:0] w1;
		logic [41:0] e;
		logic        dbl;
		int          n;
		dbl = (k == subdp_pkg::OP_DBL);
		acc[d] = ad;
		acc[s] = as;
		m = sp ? acc[s] : acc[d];
		w1 = dbl ? mem_i.mem[8'(ax[0] ? ax - 16'h1 : ax + 16'h1)] : mem_i.mem[ay[7:0]];
		e = calc(k, u, sh, m, mem_i.mem[ax[7:0]], w1, ctl, cin);
		bw(subdp_pkg::CTRL_OFS, {28'h0, ctl});
		bw(subdp_pkg::STAT_OFS, {24'h0, 4'hf, 3'h0, cin});
		wacc(d, ad);
		wacc(s, as);
		@(posedge clk);
		op_kind <= k;
		op_uns <= u;
		op_src_present <= sp;
		op_src <= s;
		op_dst <= d;
		op_shift <= sh;
		op_addr_x <= ax;
		op_addr_y <= ay;
		op_postinc <= pi;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		// a stray start mid-operation must be dropped
		for (n = 1; n < 12; n++) begin
			@(posedge clk);
			start <= poke && n == 2;
			#1;
			if (n == 1) chk("busy", 40'h1, 40'(busy));
			if (done === 1'b1) break;
		end
		// n counts from the edge that took start; done stands in the start cycle plus 4 or 5
		chk("latency", (dbl || k == subdp_pkg::OP_DUAL) ? 40'd5 : 40'd4, 40'(n + 1));
		chk("ptr_wr", 40'(pi && dbl), 40'(ptr_wr));
		if (pi && dbl) chk("ptr_next", 40'(ax + 16'h2), 40'(ptr_next));
		chk("carry", 40'(e[40]), 40'(carry_flag));
		chk("ovf_flag", 40'(4'(e[41]) << d), 40'(acc_overflow_flag));
		br(aofs(subdp_pkg::ACC_LO_OFS, d), q);
		got[31:0] = q;
		br(aofs(subdp_pkg::ACC_HI_OFS, d), q);
		got[39:32] = q[7:0];
		chk("acc", e[39:0], got);
	endtask

	initial begin
		int          k;
		logic [63:0] r64;
		logic [39:0] v0, v1;
		logic [31:0] q;
		void'($urandom(47));
		for (k = 0; k < 256; k++) mem_i.mem[k] = 16'($urandom);
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		br(subdp_pkg::CTRL_OFS, q);
		chk("ctrl_rst", 40'(subdp_pkg::CTRL_RST), 40'(q));
		br(subdp_pkg::STAT_OFS, q);
		chk("status_rst", 40'h0, 40'(q));
		br(aofs(subdp_pkg::ACC_HI_OFS, 2'd3), q);
		chk("acc_rst", 40'h0, 40'(q));
		bw(8'h0c, 32'hffff_ffff);
		br(8'h0c, q);
		chk("unmapped", 40'h0, 40'(q));
		mem_i.mem[8'h02] = 16'hf000;
		mem_i.mem[8'h10] = 16'h8000;
		run_op(subdp_pkg::OP_BORROW, 4'h2, 0, 1, 0, 0, 0, 2'd0, 2'd1, 6'h00, 16'h0302,
			16'h0000, 40'h00_ec00_0000, 40'h0);
		// positive overflow with clamping, narrow then wide; each followed by an unsigned wide shift, right then left
		for (k = 0; k < 2; k++) begin
			run_op(subdp_pkg::OP_SINGLE, k ? 4'h7 : 4'h5, 0, 1, 0, 0, 0, 2'd2, 2'd3, 6'h00,
				16'h0010, 16'h0000, k ? 40'h7f_ffff_ffff : 40'h00_7fff_ffff, 40'h0);
			run_op(subdp_pkg::OP_SHIFT, 4'h3, 1, 0, 1, 0, 0, 2'd0, 2'd0, k ? 6'h0f : 6'h30,
				16'h0010, 16'h0000, 40'h0, 40'h00_1234_5678);
		end
		for (k = 0; k < 200; k++) begin
			r64 = {$urandom, $urandom};
			v0 = r64[39:0];
			if (r64[40]) v0 = {{8{v0[31]}}, v0[31:0]};
			r64 = {$urandom, $urandom};
			v1 = r64[39:0];
			q = $urandom;
			run_op(subdp_pkg::op_kind_t'($urandom_range(0, 4)), q[3:0], q[4], q[5], q[6],
				q[7], q[8], q[10:9], q[12:11], 6'($urandom_range(0, 31) - 16), q[31:16],
				16'($urandom), v0, v1);
		end
		finish_test;
	end
endmodule

/* hdl/acc_subtract_datapath.sv */
/*
 * Accumulator subtract datapath: fetches memory operands, subtracts, saturates,
 * updates carry and per-accumulator overflow flags, holds four accumulators.
 * Assumes the decoder holds start for one cycle and memory answers a read
 * strobe with data in the next cycle.
 */
`timescale 1ns/10ps
module acc_subtract_datapath (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  start,
	input  wire subdp_pkg::op_kind_t   op_kind,
	input  wire logic                  op_uns,
	input  wire logic                  op_src_present,
	input  wire logic [1:0]            op_src,
	input  wire logic [1:0]            op_dst,
	input  wire logic [5:0]            op_shift,
	input  wire logic [15:0]           op_addr_x,
	input  wire logic [15:0]           op_addr_y,
	input  wire logic                  op_postinc,
	output logic                       busy,
	output logic                       done,
	output logic                       mem_rd,
	output logic [15:0]                mem_addr,
	input  wire logic [15:0]           mem_rdata,
	output logic                       ptr_wr,
	output logic [15:0]                ptr_next,
	output logic                       carry_flag,
	output logic [3:0]                 acc_overflow_flag,
	input  wire logic [7:0]            bus_addr,
	input  wire logic [31:0]           bus_wdata,
	input  wire logic                  bus_wr,
	input  wire logic                  bus_rd,
	output logic [31:0]                bus_rdata
);
	logic [1:0]              rst_sync_r;
	logic                    rst_n;
	subdp_pkg::state_t       state_r;
	subdp_pkg::op_kind_t     kind_r;
	logic                    uns_r;
	logic                    src_present_r;
	logic [1:0]              src_r;
	logic [1:0]              dst_r;
	logic [5:0]              shift_r;
	logic [15:0]             addr_x_r;
	logic [15:0]             addr_y_r;
	logic                    postinc_r;
	logic [15:0]             word_a_r;
	logic [15:0]             word_b_r;
	logic [3:0]              ctrl_r;
	logic                    carry_r;
	logic [3:0]              acov_r;
	logic [39:0]             acc_r [4];
	logic                    busy_r;
	logic                    done_r;
	logic                    mem_rd_r;
	logic [15:0]             mem_addr_r;
	logic                    ptr_wr_r;
	logic [15:0]             ptr_next_r;
	logic [31:0]             rdata_r;
	logic                    ovf_q_r;
	logic [39:0]             result_q_r;

	logic                    two_reads;
	logic [15:0]             lsw_addr;
	logic                    use_sign;
	logic [39:0]             ext_a;
	logic [39:0]             ext_b;
	logic [5:0]              sh_mag;
	logic [39:0]             sh_raw;
	logic                    sh_ovf;
	logic [39:0]             sh_val;
	logic [39:0]             sub_b;
	logic [39:0]             minuend;
	logic                    bin;
	logic [40:0]             diff41;
	logic [40:0]             ubor40;
	logic [32:0]             ubor32;
	logic                    ovf;
	logic                    carry_nxt;
	logic [39:0]             result;

	assign rst_n             = rst_sync_r[1];
	assign busy              = busy_r;
	assign done              = done_r;
	assign mem_rd            = mem_rd_r;
	assign mem_addr          = mem_addr_r;
	assign ptr_wr            = ptr_wr_r;
	assign ptr_next          = ptr_next_r;
	assign carry_flag        = carry_r;
	assign acc_overflow_flag = acov_r;
	assign bus_rdata         = rdata_r;

	// reset is released synchronously so all flops on rst_n leave reset on the same edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign two_reads = (kind_r == subdp_pkg::OP_DBL) || (kind_r == subdp_pkg::OP_DUAL);
	assign lsw_addr  = addr_x_r[0] ? addr_x_r - subdp_pkg::LSW_STEP
	                               : addr_x_r + subdp_pkg::LSW_STEP;

	// sequencer; a start while busy is ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= subdp_pkg::S_IDLE;
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			mem_rd_r   <= 1'b0;
			mem_addr_r <= 16'h0000;
			ptr_wr_r   <= 1'b0;
			ptr_next_r <= 16'h0000;
		end else begin
			done_r   <= 1'b0;
			ptr_wr_r <= 1'b0;
			mem_rd_r <= 1'b0;
			unique case (state_r)
				subdp_pkg::S_IDLE: begin
					if (start) begin
						state_r    <= subdp_pkg::S_RD_A;
						busy_r     <= 1'b1;
						mem_rd_r   <= 1'b1;
						mem_addr_r <= op_addr_x;
					end
				end
				subdp_pkg::S_RD_A: begin
					if (two_reads) begin
						state_r    <= subdp_pkg::S_RD_B;
						mem_rd_r   <= 1'b1;
						mem_addr_r <= (kind_r == subdp_pkg::OP_DBL) ? lsw_addr : addr_y_r;
					end else begin
						state_r <= subdp_pkg::S_CAP;
					end
				end
				subdp_pkg::S_RD_B: state_r <= subdp_pkg::S_CAP;
				subdp_pkg::S_CAP:  state_r <= subdp_pkg::S_EXEC;
				subdp_pkg::S_EXEC: begin
					state_r    <= subdp_pkg::S_IDLE;
					busy_r     <= 1'b0;
					done_r     <= 1'b1;
					ptr_wr_r   <= postinc_r && (kind_r == subdp_pkg::OP_DBL);
					ptr_next_r <= addr_x_r + subdp_pkg::PTR_STEP;
				end
			endcase
		end
	end

	// operation capture and operand words
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kind_r        <= subdp_pkg::OP_SINGLE;
			uns_r         <= 1'b0;
			src_present_r <= 1'b0;
			src_r         <= 2'b00;
			dst_r         <= 2'b00;
			shift_r       <= 6'h00;
			addr_x_r      <= 16'h0000;
			addr_y_r      <= 16'h0000;
			postinc_r     <= 1'b0;
			word_a_r      <= 16'h0000;
			word_b_r      <= 16'h0000;
		end else begin
			if (state_r == subdp_pkg::S_IDLE && start) begin
				kind_r        <= op_kind;
				uns_r         <= op_uns;
				src_present_r <= op_src_present;
				src_r         <= op_src;
				dst_r         <= op_dst;
				shift_r       <= op_shift;
				addr_x_r      <= op_addr_x;
				addr_y_r      <= op_addr_y;
				postinc_r     <= op_postinc;
			end
			if (state_r == subdp_pkg::S_RD_B) begin
				word_a_r <= mem_rdata;
			end
			if (state_r == subdp_pkg::S_CAP) begin
				if (two_reads) begin
					word_b_r <= mem_rdata;
				end else begin
					word_a_r <= mem_rdata;
				end
			end
		end
	end

	// arithmetic at accumulator width, except the narrow-mode carry, which comes from a 32-bit subtraction
	always_comb begin
		use_sign = ctrl_r[subdp_pkg::CTRL_SIGN_EXTENSION_MODE];
		// uns only qualifies a single memory operand; dbl and dual ignore it
		if (uns_r && (kind_r == subdp_pkg::OP_SINGLE || kind_r == subdp_pkg::OP_SHIFT)) begin
			use_sign = 1'b0;
		end
		if (kind_r == subdp_pkg::OP_BORROW) begin
			use_sign = 1'b0;
		end
		ext_a  = use_sign ? {{24{word_a_r[15]}}, word_a_r} : {24'h00_0000, word_a_r};
		ext_b  = use_sign ? {{24{word_b_r[15]}}, word_b_r} : {24'h00_0000, word_b_r};
		sh_mag = shift_r[5] ? 6'(~shift_r + 6'h01) : shift_r;
		sh_raw = shift_r[5] ? 40'($signed(ext_a) >>> sh_mag) : ext_a << sh_mag;
		// compat mode shifts as if wide, so no narrow check on the shift
		sh_ovf = (kind_r == subdp_pkg::OP_SHIFT) && !ctrl_r[subdp_pkg::CTRL_C54]
		      && !ctrl_r[subdp_pkg::CTRL_M40]
		      && !(&sh_raw[39:31] || !(|sh_raw[39:31]));
		sh_val = sh_raw;
		if (sh_ovf && ctrl_r[subdp_pkg::CTRL_DATAPATH_SATURATION_MODE]) begin
			sh_val = ext_a[39] ? subdp_pkg::SAT_NEG32 : subdp_pkg::SAT_POS32;
		end
		unique case (kind_r)
			subdp_pkg::OP_SHIFT: sub_b = sh_val;
			subdp_pkg::OP_DBL: begin
				sub_b = use_sign ? {{8{word_a_r[15]}}, word_a_r, word_b_r}
				                 : {8'h00, word_a_r, word_b_r};
			end
			subdp_pkg::OP_DUAL: sub_b = ext_b << subdp_pkg::DUAL_SHIFT;
			default:            sub_b = ext_a;
		endcase
		if (kind_r == subdp_pkg::OP_DUAL) begin
			minuend = ext_a << subdp_pkg::DUAL_SHIFT;
		end else begin
			minuend = src_present_r ? acc_r[src_r] : acc_r[dst_r];
		end
		bin    = (kind_r == subdp_pkg::OP_BORROW) ? !carry_r : 1'b0;
		diff41 = {minuend[39], minuend} - {sub_b[39], sub_b} - {40'h00_0000_0000, bin};
		ubor40 = {1'b0, minuend} - {1'b0, sub_b} - {40'h00_0000_0000, bin};
		ubor32 = {1'b0, minuend[31:0]} - {1'b0, sub_b[31:0]} - {32'h0000_0000, bin};
		if (ctrl_r[subdp_pkg::CTRL_M40]) begin
			ovf       = diff41[40] ^ diff41[subdp_pkg::OVF_BIT_WIDE];
			carry_nxt = !ubor40[40];
		end else begin
			ovf       = (diff41[40] ^ diff41[39]) || !(&diff41[39:31] || !(|diff41[39:31]));
			carry_nxt = !ubor32[32];
		end
		result = diff41[39:0];
		if (ovf && ctrl_r[subdp_pkg::CTRL_DATAPATH_SATURATION_MODE]) begin
			if (ctrl_r[subdp_pkg::CTRL_M40]) begin
				result = diff41[40] ? subdp_pkg::SAT_NEG40 : subdp_pkg::SAT_POS40;
			end else begin
				result = diff41[40] ? subdp_pkg::SAT_NEG32 : subdp_pkg::SAT_POS32;
			end
		end
	end

	// accumulators; the datapath write wins over a bus write to the same one
	for (genvar i = 0; i < subdp_pkg::NUM_ACC; i++) begin : g_acc
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				acc_r[i] <= subdp_pkg::ACC_RST;
			end else if (state_r == subdp_pkg::S_EXEC && dst_r == 2'(i)) begin
				acc_r[i] <= result;
			end else if (bus_wr && bus_addr == subdp_pkg::ACC_LO_OFS
			             + 8'(i) * subdp_pkg::ACC_STRIDE) begin
				acc_r[i][31:0] <= bus_wdata;
			end else if (bus_wr && bus_addr == subdp_pkg::ACC_HI_OFS
			             + 8'(i) * subdp_pkg::ACC_STRIDE) begin
				acc_r[i][39:32] <= bus_wdata[7:0];
			end
		end
	end

	// mode bits, carry and sticky overflow flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r     <= subdp_pkg::CTRL_RST;
			carry_r    <= subdp_pkg::CARRY_RST;
			acov_r     <= subdp_pkg::ACOV_RST;
			ovf_q_r    <= 1'b0;
			result_q_r <= subdp_pkg::ACC_RST;
		end else begin
			if (bus_wr && bus_addr == subdp_pkg::CTRL_OFS) begin
				ctrl_r <= bus_wdata[3:0];
			end
			// set beats write-one-to-clear in the same cycle
			if (state_r == subdp_pkg::S_EXEC) begin
				carry_r    <= carry_nxt;
				ovf_q_r    <= ovf || sh_ovf;
				result_q_r <= result;
				acov_r     <= (bus_wr && bus_addr == subdp_pkg::STAT_OFS)
				            ? acov_r & ~bus_wdata[subdp_pkg::STAT_ACOV +: 4] : acov_r;
				if (ovf || sh_ovf) begin
					acov_r[dst_r] <= 1'b1;
				end
			end else if (bus_wr && bus_addr == subdp_pkg::STAT_OFS) begin
				carry_r <= bus_wdata[subdp_pkg::STAT_CARRY];
				acov_r  <= acov_r & ~bus_wdata[subdp_pkg::STAT_ACOV +: 4];
			end
		end
	end

	// register read port; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_rd) begin
			rdata_r <= 32'h0000_0000;
			if (bus_addr == subdp_pkg::CTRL_OFS) begin
				rdata_r <= {28'h000_0000, ctrl_r};
			end
			if (bus_addr == subdp_pkg::STAT_OFS) begin
				rdata_r <= {24'h00_0000, acov_r, 3'b000, carry_r};
			end
			for (int j = 0; j < subdp_pkg::NUM_ACC; j++) begin
				if (bus_addr == subdp_pkg::ACC_LO_OFS + 8'(j) * subdp_pkg::ACC_STRIDE) begin
					rdata_r <= acc_r[j][31:0];
				end
				if (bus_addr == subdp_pkg::ACC_HI_OFS + 8'(j) * subdp_pkg::ACC_STRIDE) begin
					rdata_r <= {24'h00_0000, acc_r[j][39:32]};
				end
			end
		end
	end

	a_done_latency: assert property (@(posedge clk) disable iff (!rst_n)
		(start && state_r == subdp_pkg::S_IDLE) |-> ##[4:5] done_r)
		else $error("operation did not finish in time");
	a_lsw_address: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_RD_A && kind_r == subdp_pkg::OP_DBL) |=>
		(mem_rd_r && mem_addr_r == (addr_x_r[0] ? addr_x_r - 16'h0001 : addr_x_r + 16'h0001)))
		else $error("wrong least significant word address");
	a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
		ptr_wr_r |-> (done_r && ptr_next_r == addr_x_r + 16'h0002))
		else $error("pointer not advanced by two");
	a_overflow_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(done_r && ovf_q_r) |-> acov_r[dst_r])
		else $error("overflow flag not set");
	a_sat_wide: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && ovf && ctrl_r[2] && ctrl_r[1]) |=>
		(acc_r[dst_r] == 40'h7f_ffff_ffff || acc_r[dst_r] == 40'h80_0000_0000))
		else $error("saturation value wrong");
	a_zero_no_borrow: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && kind_r != subdp_pkg::OP_BORROW && sub_b == 40'h0)
		|=> carry_r)
		else $error("carry cleared without borrow");
	a_uns_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && kind_r == subdp_pkg::OP_SINGLE && uns_r)
		|-> sub_b[39:16] == 24'h0)
		else $error("unsigned operand not zero extended");
	a_dual_align: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && kind_r == subdp_pkg::OP_DUAL)
		|-> (sub_b[15:0] == 16'h0 && minuend[15:0] == 16'h0 && sub_b[31:16] == word_b_r))
		else $error("dual operands not aligned");
	a_compat_shift: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && ctrl_r[3]) |-> !sh_ovf)
		else $error("shift overflow in compat mode");
	a_default_minuend: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == subdp_pkg::S_EXEC && !src_present_r && kind_r != subdp_pkg::OP_DUAL)
		|-> minuend == acc_r[dst_r])
		else $error("minuend is not destination");
endmodule

/* hdl/subdp_pkg.sv */
/*
 * Constants and types of the accumulator subtract datapath.
 * Assumes 16-bit data memory words, 40-bit accumulators, and a register
 * port with 8-bit byte addresses and 32-bit data.
 */
package subdp_pkg;
	localparam int ACC_W    = 40;
	localparam int WORD_W   = 16;
	localparam int ADDR_W   = 16;
	localparam int BUS_AW   = 8;
	localparam int NUM_ACC  = 4;
	localparam int IDX_W    = 2;
	localparam int SHIFT_W  = 6;

	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STAT_OFS   = 8'h04;
	localparam logic [7:0] ACC_LO_OFS = 8'h10;
	localparam logic [7:0] ACC_HI_OFS = 8'h20;
	localparam logic [7:0] ACC_STRIDE = 8'h04;

	localparam int CTRL_SIGN_EXTENSION_MODE  = 0;
	localparam int CTRL_M40   = 1;
	localparam int CTRL_DATAPATH_SATURATION_MODE  = 2;
	localparam int CTRL_C54   = 3;
	localparam int STAT_CARRY = 0;
	localparam int STAT_ACOV  = 4;

	localparam logic [3:0]  CTRL_RST  = 4'h0;
	localparam logic        CARRY_RST = 1'b0;
	localparam logic [3:0]  ACOV_RST  = 4'h0;
	localparam logic [39:0] ACC_RST   = 40'h00_0000_0000;

	localparam int OVF_BIT_NARROW = 31;
	localparam int OVF_BIT_WIDE   = 39;
	localparam int DUAL_SHIFT     = 16;

	localparam logic [39:0] SAT_POS40 = 40'h7f_ffff_ffff;
	localparam logic [39:0] SAT_NEG40 = 40'h80_0000_0000;
	localparam logic [39:0] SAT_POS32 = 40'h00_7fff_ffff;
	localparam logic [39:0] SAT_NEG32 = 40'hff_8000_0000;

	localparam logic [15:0] PTR_STEP = 16'h0002;
	localparam logic [15:0] LSW_STEP = 16'h0001;

	typedef enum logic [2:0] {
		OP_SINGLE,
		OP_SHIFT,
		OP_DBL,
		OP_BORROW,
		OP_DUAL
	} op_kind_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RD_A,
		S_RD_B,
		S_CAP,
		S_EXEC
	} state_t;
endpackage
